// >>> rtl/bioc_unit.sv
// Eight-pin bit input/output unit with pattern compare and condition flags.
// Assumes pins and core strobes are synchronous to MCLK_I; the pad
// wires are resolved outside from USER_PIN_O and USER_PIN_OE_O.
//
// How it works
// - Eight pins, each input or output by its upper direction bit.
// - Lower status byte always reports the pin levels sampled one clock earlier.
// - Pin-level byte is readable; writes to it change nothing.
// - On owned pins, output buffer enabled only while direction selects output.
// - Control upper bit selects meaning of lower bit, per direction.
// - Output pin, mode 0: pin takes the written data bit.
// - Output pin, mode 1: data 1 toggles, data 0 holds.
// - Output value is kept while a pin is temporarily an input.
// - Control write compares pattern with input pins where mask is 1.
// - Four flags: all match, none match, some match, some mismatch.
// - Upper four pins are ours only while upper select is set.
// - Lower four pins are ours only while lower select is set.
// - After reset the upper pins drive the vector outputs low.
// - A tested bit matches only when level equals pattern bit.
// - Reset sets all direction bits to input and clears stored outputs.
// - Flags update on control writes; flag word restores them.

`timescale 1ns/100ps

module bioc_unit
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic DIR_WR_I,
    input wire logic CTRL_WR_I,
    input wire logic [15:0] WDATA_I,
    output logic [15:0] DIR_RDATA_O,
    output logic [15:0] CTRL_RDATA_O,
    output logic [3:0] FLAGS_O,
    input wire logic FLAG_WR_I,
    input wire logic [3:0] FLAG_WDATA_I,
    input wire logic UPPER_PINS_SELECT_I,
    input wire logic LOWER_PINS_SELECT_I,
    input wire logic [3:0] INTERRUPT_VECTOR_OUT_I,
    input wire logic [3:0] HOST_PORT_DATA_I,
    input wire logic [3:0] HOST_PORT_DATA_OE_I,
    output logic [3:0] HOST_PORT_DATA_O,
    input wire logic [7:0] USER_PIN_I,
    output logic [7:0] USER_PIN_O,
    output logic [7:0] USER_PIN_OE_O
);

    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [7:0] out_q;
    logic [7:0] out_d;
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [7:0] pin_q;
    logic [7:0] pin_d;
    logic [7:0] oe_q;
    logic [7:0] oe_d;
    logic [3:0] host_q;
    logic [3:0] host_d;
    logic [7:0] mode;
    logic [7:0] data;
    logic [7:0] tested;
    logic [7:0] match;
    logic [7:0] bio_own;

    // Fields of the incoming control word
    assign mode = WDATA_I[bioc_pkg::MODE_LSB +: bioc_pkg::PIN_W];
    assign data = WDATA_I[bioc_pkg::DATA_LSB +: bioc_pkg::PIN_W];

    // Pattern compare on inputs selected by the mask
    // masked input test
    assign tested = mode & ~dir_q;
    assign match = tested & ~(USER_PIN_I ^ data);

    // Which pins this unit currently owns
    // upper and lower pins select
    assign bio_own = {{bioc_pkg::HALF_W{UPPER_PINS_SELECT_I}},
                      {bioc_pkg::HALF_W{LOWER_PINS_SELECT_I}}};

    // Next register state
    always_comb
    begin
        dir_d = dir_q;
        out_d = out_q;
        ctrl_d = ctrl_q;
        flags_d = flags_q;
        if (DIR_WR_I)
        begin
            dir_d = WDATA_I[bioc_pkg::DIR_LSB +: bioc_pkg::PIN_W];
        end
        if (FLAG_WR_I)
        begin
            flags_d = FLAG_WDATA_I;
        end
        // Compare result is applied after any restore, so it wins
        // single write does both
        if (CTRL_WR_I)
        begin
            ctrl_d = WDATA_I;
            out_d = (dir_q & ~mode & data) | (dir_q & mode & (out_q ^ data))
                  | (~dir_q & out_q);
            flags_d[bioc_pkg::FLAG_ALL_TRUE] = (match == tested);
            flags_d[bioc_pkg::FLAG_ALL_FALSE] = (match == 8'h00);
            flags_d[bioc_pkg::FLAG_SOME_TRUE] = |match;
            flags_d[bioc_pkg::FLAG_SOME_FALSE] = |(tested & ~match);
        end
    end

    // Control and flag registers
    // reset to inputs, zero out
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            dir_q <= bioc_pkg::DIR_RESET;
            out_q <= bioc_pkg::OUT_RESET;
            ctrl_q <= bioc_pkg::CTRL_RESET;
            flags_q <= bioc_pkg::FLAG_RESET;
        end
        else
        begin
            dir_q <= dir_d;
            out_q <= out_d;
            ctrl_q <= ctrl_d;
            flags_q <= flags_d;
        end
    end

    // Pin drive, status word and host data, registered toward the pads
    always_comb
    begin
        stat_d = {dir_q, USER_PIN_I};
        host_d = USER_PIN_I[3:0];
        pin_d = out_d;
        oe_d = dir_d & bio_own;
        if (!UPPER_PINS_SELECT_I)
        begin
            pin_d[7:4] = {INTERRUPT_VECTOR_OUT_I[0], INTERRUPT_VECTOR_OUT_I[1],
                          INTERRUPT_VECTOR_OUT_I[2], INTERRUPT_VECTOR_OUT_I[3]};
            oe_d[7:4] = 4'hF;
        end
        if (!LOWER_PINS_SELECT_I)
        begin
            pin_d[3:0] = HOST_PORT_DATA_I;
            oe_d[3:0] = HOST_PORT_DATA_OE_I;
        end
    end

    // Output flops; vector pins start driven low
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            // Upper pads drive the vectors low so they never float
            stat_q <= bioc_pkg::STAT_RESET;
            host_q <= bioc_pkg::HOST_RESET;
            pin_q <= {bioc_pkg::VEC_RESET, bioc_pkg::LOW_PIN_RESET};
            oe_q <= bioc_pkg::PIN_OE_RESET;
        end
        else
        begin
            stat_q <= stat_d;
            host_q <= host_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign DIR_RDATA_O = stat_q;
    assign CTRL_RDATA_O = ctrl_q;
    assign FLAGS_O = flags_q;
    assign HOST_PORT_DATA_O = host_q;
    assign USER_PIN_O = pin_q;
    assign USER_PIN_OE_O = oe_q;

    // Checks
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence ctrl_write_s;
        CTRL_WR_I && !FLAG_WR_I;
    endsequence

    sequence all_out_s;
        (dir_q == 8'hFF) && UPPER_PINS_SELECT_I && LOWER_PINS_SELECT_I;
    endsequence

    dir_readback_a: assert property (DIR_WR_I |=> ##1
        DIR_RDATA_O[15:8] == $past(WDATA_I[15:8], 2))
        else $error("direction byte not reported");

    dir_write_a: assert property (DIR_WR_I |=>
        dir_q == $past(WDATA_I[15:8]))
        else $error("direction register not written");

    level_report_a: assert property (1'b1 |=>
        DIR_RDATA_O[7:0] == $past(USER_PIN_I))
        else $error("pin level not reported");

    oe_owned_a: assert property (UPPER_PINS_SELECT_I
        && LOWER_PINS_SELECT_I && !DIR_WR_I |=> USER_PIN_OE_O == $past(dir_q))
        else $error("output enable does not follow direction");

    oe_written_a: assert property (UPPER_PINS_SELECT_I
        && LOWER_PINS_SELECT_I && DIR_WR_I
        |=> USER_PIN_OE_O == $past(WDATA_I[15:8]))
        else $error("output enable misses new direction");

    data_mode_a: assert property (ctrl_write_s and all_out_s
        and (WDATA_I[15:8] == 8'h00)
        |=> USER_PIN_O == $past(WDATA_I[7:0]))
        else $error("data mode drive wrong");

    toggle_mode_a: assert property (ctrl_write_s and all_out_s
        and (WDATA_I[15:8] == 8'hFF)
        |=> out_q == ($past(out_q) ^ $past(WDATA_I[7:0])))
        else $error("toggle mode wrong");

    input_hold_a: assert property ((dir_q == 8'h00)
        |=> out_q == $past(out_q))
        else $error("stored output lost while input");

    resume_drive_a: assert property (DIR_WR_I && !CTRL_WR_I
        && UPPER_PINS_SELECT_I && LOWER_PINS_SELECT_I
        |=> USER_PIN_O == $past(out_q))
        else $error("stored output not resumed");

    all_true_a: assert property (ctrl_write_s and (dir_q == 8'h00)
        and (WDATA_I[15:8] == 8'hFF) and (USER_PIN_I == WDATA_I[7:0])
        |=> FLAGS_O == 4'h5)
        else $error("all true flags wrong");

    flag_pairs_a: assert property (CTRL_WR_I |=>
        (FLAGS_O[bioc_pkg::FLAG_SOME_TRUE]
        != FLAGS_O[bioc_pkg::FLAG_ALL_FALSE])
        && (FLAGS_O[bioc_pkg::FLAG_SOME_FALSE]
        != FLAGS_O[bioc_pkg::FLAG_ALL_TRUE]))
        else $error("condition flags contradict");

    none_tested_a: assert property (ctrl_write_s
        and (WDATA_I[15:8] == 8'h00) |=> FLAGS_O == 4'h3)
        else $error("untested pins affected flags");

    no_inputs_a: assert property (ctrl_write_s and all_out_s
        and (WDATA_I[15:8] == 8'hFF) |=> FLAGS_O == 4'h3)
        else $error("output pins entered the compare");

    none_match_a: assert property (ctrl_write_s
        and (dir_q == 8'h00) and (WDATA_I[15:8] == 8'hFF)
        and (USER_PIN_I == ~WDATA_I[7:0]) |=> FLAGS_O == 4'hA)
        else $error("mismatch flags wrong");

    flags_hold_a: assert property (!CTRL_WR_I && !FLAG_WR_I
        |=> $stable(FLAGS_O))
        else $error("flags changed without write");

    flag_restore_a: assert property (FLAG_WR_I && !CTRL_WR_I
        |=> FLAGS_O == $past(FLAG_WDATA_I))
        else $error("flag restore not taken");

    ctrl_readback_a: assert property (CTRL_WR_I
        |=> CTRL_RDATA_O == $past(WDATA_I))
        else $error("control word not kept");

    vector_pins_a: assert property (!UPPER_PINS_SELECT_I
        |=> USER_PIN_OE_O[7:4] == 4'hF)
        else $error("vector pins not driven");

    vector_order_a: assert property (!UPPER_PINS_SELECT_I
        |=> (USER_PIN_O[7] == $past(INTERRUPT_VECTOR_OUT_I[0]))
        && (USER_PIN_O[6] == $past(INTERRUPT_VECTOR_OUT_I[1]))
        && (USER_PIN_O[5] == $past(INTERRUPT_VECTOR_OUT_I[2]))
        && (USER_PIN_O[4] == $past(INTERRUPT_VECTOR_OUT_I[3])))
        else $error("vector outputs misplaced");

    host_pins_a: assert property (!LOWER_PINS_SELECT_I
        |=> (USER_PIN_O[3:0] == $past(HOST_PORT_DATA_I))
        && (USER_PIN_OE_O[3:0] == $past(HOST_PORT_DATA_OE_I)))
        else $error("host port data not on lower pins");

    host_level_a: assert property (1'b1 |=>
        HOST_PORT_DATA_O == $past(USER_PIN_I[3:0]))
        else $error("host port level not reported");

endmodule

// >>> pkg/bioc_pkg.sv
// Constants for the bit input/output compare unit.
// Assumes one core clock and an asynchronous active-low system reset.
package bioc_pkg;
    // Pin count and register geometry
    localparam int PIN_W = 8;
    localparam int REG_W = 16;
    localparam int HALF_W = 4;
    // Direction/level register: direction in the upper byte, levels below
    localparam int DIR_LSB = 8;
    localparam int LEVEL_LSB = 0;
    // Control register: mode/mask upper byte, data/pattern lower byte
    localparam int MODE_LSB = 8;
    localparam int DATA_LSB = 0;
    // I/O configuration bits that hand the pins to this unit
    localparam int CFG_UPPER_BIT = 12;
    localparam int CFG_LOWER_BIT = 10;
    // Condition flag positions in the processor flag word
    localparam int FLAG_ALL_TRUE = 0;
    localparam int FLAG_ALL_FALSE = 1;
    localparam int FLAG_SOME_TRUE = 2;
    localparam int FLAG_SOME_FALSE = 3;
    localparam int FLAG_W = 4;
    // Values after reset
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [3:0] VEC_RESET = 4'h0;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [3:0] HOST_RESET = 4'h0;
    localparam logic [3:0] LOW_PIN_RESET = 4'h0;
    localparam logic [7:0] PIN_OE_RESET = 8'hF0;
endpackage

// >>> verif/bioc_ext.sv
// External status and control lines facing the eight user pins.
// Assumes the bench sets the drive value and drive enable per pin.
`timescale 1ns/100ps
module bioc_ext
(
    input wire logic clk_i,
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] drv_en_i,
    output logic [7:0] lvl_o
);
    logic [7:0] last_q;
    // Device wins, then outside drive, else the wire drifts off
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            lvl_o[i] = pin_oe_i[i] ? pin_o_i[i]
                : (drv_en_i[i] ? drv_i[i] : ~last_q[i]);
    end
    // Last level seen, for the drifting undriven wire
    always_ff @(posedge clk_i)
        last_q <= lvl_o;
endmodule

// >>> verif/tb.sv
// Self-checking bench for the bit input/output compare unit.
// Assumes bioc_ext models the outside lines on the user pins.
`timescale 1ns/100ps
module tb;
    logic clk, rst_n, dir_wr, ctrl_wr, flag_wr, up_sel, lo_sel;
    logic [15:0] wdata, dir_rd, ctrl_rd;
    logic [3:0] flag_wd, vec, hp_d, hp_oe, flags, hp_o;
    logic [7:0] drv, drv_en, lvl, pin_o, pin_oe;
    int failures, cmp_count, cyc;
    bioc_unit i_dut (.MCLK_I(clk), .RESETN_I(rst_n),
        .DIR_WR_I(dir_wr), .CTRL_WR_I(ctrl_wr), .WDATA_I(wdata),
        .DIR_RDATA_O(dir_rd), .CTRL_RDATA_O(ctrl_rd), .FLAGS_O(flags),
        .FLAG_WR_I(flag_wr), .FLAG_WDATA_I(flag_wd),
        .UPPER_PINS_SELECT_I(up_sel), .LOWER_PINS_SELECT_I(lo_sel),
        .INTERRUPT_VECTOR_OUT_I(vec), .HOST_PORT_DATA_I(hp_d),
        .HOST_PORT_DATA_OE_I(hp_oe), .HOST_PORT_DATA_O(hp_o),
        .USER_PIN_I(lvl), .USER_PIN_O(pin_o), .USER_PIN_OE_O(pin_oe));
    bioc_ext i_ext (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .drv_i(drv), .drv_en_i(drv_en), .lvl_o(lvl));
    // Compare and count
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe, then let pads and read-back settle
    task wr(input logic ctl, input logic [15:0] d);
        @(posedge clk);
        wdata <= d;
        dir_wr <= !ctl;
        ctrl_wr <= ctl;
        @(posedge clk);
        dir_wr <= 1'b0;
        ctrl_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task wrap_up;
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Shared pins after reset, then handed to the unit
    task t_mux;
        repeat (2) @(posedge clk);
        #1;
        chk({pin_oe[7:4], pin_o[7:4]}, 16'h00F0);
        chk(dir_rd, 16'h0000);
        @(posedge clk);
        vec <= 4'h1;
        hp_d <= 4'h5;
        hp_oe <= 4'hF;
        repeat (3) @(posedge clk);
        #1;
        chk(pin_o[7:4], 16'h0008);
        chk(hp_o, 16'h0005);
        @(posedge clk);
        up_sel <= 1'b1;
        lo_sel <= 1'b1;
        drv_en <= 8'hFF;
    endtask
    // Data and toggle modes with a compare in the same write
    task t_out;
        drv <= 8'h5B;
        wr(1'b0, 16'hF000);
        wr(1'b1, 16'h0000);
        chk({pin_oe, pin_o}, 16'hF000);
        wr(1'b1, 16'hF0C0);
        chk(pin_o[7:4], 16'h000C);
        wr(1'b1, 16'h0FAB);
        chk(pin_o[7:4], 16'h000A);
        chk(flags, 16'h0005);
        chk(ctrl_rd, 16'h0FAB);
        chk(dir_rd, 16'hF0AB);
    endtask
    // Back to input and out again keeps the stored value
    task t_keep;
        wr(1'b0, 16'h00FF);
        chk(pin_oe, 16'h0000);
        chk(dir_rd, 16'h005B);
        wr(1'b0, 16'hF000);
        chk({pin_oe, pin_o[7:4]}, 16'h0F0A);
    endtask
    // All outputs: set, clear, toggle and hold per bit
    task t_all_out;
        wr(1'b0, 16'hFF00);
        wr(1'b1, 16'h0055);
        chk({pin_oe, pin_o}, 16'hFF55);
        chk(flags, 16'h0003);
        wr(1'b1, 16'hFF0F);
        chk(pin_o, 16'h005A);
        wr(1'b1, 16'hCC93);
        chk(pin_o, 16'h00DB);
        chk(dir_rd, 16'hFFDB);
    endtask
    // Compare table on all inputs, then flag restore
    task t_flags;
        logic [15:0] c [6];
        logic [3:0] e [6];
        c = '{16'hFFAB, 16'hFF54, 16'h0302, 16'h0300, 16'h00AB, 16'h0F0B};
        e = '{4'h5, 4'hA, 4'hC, 4'hA, 4'h3, 4'h5};
        drv <= 8'hAB;
        wr(1'b0, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            wr(1'b1, c[i]);
            chk(flags, 16'(e[i]));
        end
        @(posedge clk);
        flag_wd <= 4'h9;
        flag_wr <= 1'b1;
        @(posedge clk);
        flag_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(flags, 16'h0009);
        @(posedge clk);
        wdata <= 16'hFFAB;
        ctrl_wr <= 1'b1;
        flag_wr <= 1'b1;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        flag_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(flags, 16'h0005);
    endtask
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            wrap_up();
        end
    end
    // Main sequence
    initial
    begin
        {rst_n, dir_wr, ctrl_wr, flag_wr, up_sel, lo_sel} = 6'h00;
        {wdata, flag_wd, vec, hp_d, hp_oe} = 32'h0;
        {drv, drv_en} = 16'h000F;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_mux();
        t_out();
        t_keep();
        t_all_out();
        t_flags();
        wrap_up();
    end
endmodule
